// ==== core/logic_string_cfg.svh ====
// Opcode patterns, field codes and clock counts for the logic and string decoder
`ifndef LOGIC_STRING_CFG_SVH
`define LOGIC_STRING_CFG_SVH

// Opcode patterns with the width bit (and direction bit) cleared; translate D7 and prefix F3 are exact bytes
`define OPC_AND_RM       8'h20
`define OPC_AND_MR       8'h22
`define OPC_AND_ACC      8'h24
`define OPC_IMM_GRP      8'h80
`define OPC_TEST_RM      8'h84
`define OPC_UNARY_GRP    8'hF6
`define OPC_TEST_ACC     8'hA8
`define OPC_OR_RM        8'h08
`define OPC_OR_MR        8'h0A
`define OPC_OR_ACC       8'h0C
`define OPC_XOR_RM       8'h30
`define OPC_XOR_MR       8'h32
`define OPC_XOR_ACC      8'h34
`define OPC_STR_CMP      8'hA6
`define OPC_STR_IN       8'h6C
`define OPC_STR_OUT      8'h6E
`define OPC_STR_LOAD     8'hAC
`define OPC_STR_MOVE     8'hA4
`define OPC_STR_SCAN     8'hAE
`define OPC_STR_STORE    8'hAA
`define OPC_TRANSLATE    8'hD7
`define PFX_REP_EQUAL    8'hF3

// Middle field codes of the addressing byte
`define EXT_AND          3'h4
`define EXT_OR           3'h1
`define EXT_XOR          3'h6
`define EXT_TEST         3'h0
`define EXT_NOT          3'h2

// Register mode value of the addressing byte's top field
`define MOD_REGISTER     2'h3

// Clock counts
`define CLK_REG_OP       8'h02
`define CLK_RM_TO_MEM    8'h07
`define CLK_MEM_TO_REG   8'h06
`define CLK_TEST_MEM     8'h05
`define CLK_NOT_MEM      8'h06
`define CLK_CMP          8'h0A
`define CLK_IN_REAL      8'h0F
`define CLK_IN_LOW       8'h09
`define CLK_IN_HIGH      8'h1D
`define CLK_OUT_REAL     8'h0E
`define CLK_OUT_LOW      8'h08
`define CLK_OUT_HIGH     8'h1C
`define CLK_LOAD         8'h05
`define CLK_MOVE         8'h08
`define CLK_SCAN         8'h08
`define CLK_STORE        8'h05
`define CLK_TRANS        8'h05
`define CLK_REPT_BASE    8'h05
`define CLK_REPT_ITER    8'h09

`endif

// ==== core/logic_string_pkg.sv ====
// Types shared by the logic and string decoder
package logic_string_pkg;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_AND   = 4'h1,
        OP_OR    = 4'h2,
        OP_XOR   = 4'h3,
        OP_TEST  = 4'h4,
        OP_NOT   = 4'h5,
        OP_SCMP  = 4'h6,
        OP_SIN   = 4'h7,
        OP_SOUT  = 4'h8,
        OP_SLOAD = 4'h9,
        OP_SMOVE = 4'hA,
        OP_SSCAN = 4'hB,
        OP_SSTOR = 4'hC,
        OP_TRANS = 4'hD
    } op_kind_t;

    // Operating mode
    typedef enum logic [1:0] {
        MODE_REAL      = 2'h0,
        MODE_VIRTUAL   = 2'h1,
        MODE_PROTECTED = 2'h2
    } cpu_mode_t;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_EXEC   = 4'b0010,
        ST_REPEAT = 4'b0100,
        ST_DONE   = 4'b1000
    } seq_state_t;

endpackage : logic_string_pkg

// ==== core/decode_bus_if.sv ====
// Decoded instruction bundle passed from decoder to sequencer
`timescale 1ns/1ps
interface decode_bus_if;
    import logic_string_pkg::*;
    op_kind_t   op;          // Decoded operation
    logic       valid;       // Opcode recognised
    logic       full_width;  // Width bit set
    logic       writes;      // Result written back
    logic       repeat_eq;   // Repeat-while-equal prefix present on a string compare
    logic [7:0] clocks;      // Clock count of one execution
    logic [7:0] iter_clocks; // Clocks per repeated iteration

    modport producer (output op, valid, full_width, writes, repeat_eq, clocks, iter_clocks);
    modport consumer (input  op, valid, full_width, writes, repeat_eq, clocks, iter_clocks);
endinterface : decode_bus_if

// ==== core/op_decoder.sv ====
// Combinational opcode decoder with per-form clock counts
`timescale 1ns/1ps
`include "logic_string_cfg.svh"
module op_decoder
    import logic_string_pkg::*;
(
    input  wire logic        prefix_valid_i,  // Prefix byte present
    input  wire logic [7:0]  prefix_i,        // Prefix byte
    input  wire logic [7:0]  opcode_i,        // Opcode byte
    input  wire logic [7:0]  modrm_i,         // Addressing byte
    input  wire cpu_mode_t   mode_i,          // Operating mode
    input  wire logic [1:0]  current_privilege_level_i, // Current privilege level
    input  wire logic [1:0]  io_privilege_threshold_i,  // I/O privilege threshold
    decode_bus_if.producer   dec              // Decoded bundle
);
    logic [7:0] opc_w0;     // Opcode with width bit cleared
    logic [7:0] opc_dw0;    // Opcode with direction and width cleared
    logic [2:0] ext;        // Middle field
    logic       reg_form;   // Operand is a register
    logic       io_low;     // Privilege allows short port count

    assign opc_w0   = {opcode_i[7:1], 1'b0};
    assign opc_dw0  = {opcode_i[7:2], 2'b00};
    assign ext      = modrm_i[5:3];
    assign reg_form = (modrm_i[7:6] == `MOD_REGISTER);
    assign io_low   = (current_privilege_level_i <= io_privilege_threshold_i);

    // Width and prefix flags
    always_comb begin
        dec.full_width = opcode_i[0];
        dec.repeat_eq  = prefix_valid_i && (prefix_i == `PFX_REP_EQUAL)
                         && (opc_w0 == `OPC_STR_CMP);
        dec.iter_clocks = `CLK_REPT_ITER;
    end

    // Operation and clock count lookup
    always_comb begin
        dec.op     = OP_NONE;
        dec.valid  = 1'b1;
        dec.writes = 1'b1;
        dec.clocks = `CLK_REG_OP;
        if (opcode_i == `OPC_TRANSLATE) begin                  // Exact byte
            dec.op     = OP_TRANS;
            dec.clocks = `CLK_TRANS;
        end else if (opc_w0 == `OPC_AND_RM) begin
            dec.op     = OP_AND;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_RM_TO_MEM;
        end else if (opc_w0 == `OPC_AND_MR) begin
            dec.op     = OP_AND;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_MEM_TO_REG;
        end else if (opc_w0 == `OPC_AND_ACC) begin
            dec.op     = OP_AND;
        end else if ({opcode_i[7:2], 2'b00} == `OPC_IMM_GRP && ext == `EXT_AND) begin
            dec.op     = OP_AND;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_RM_TO_MEM;
        end else if ({opcode_i[7:2], 2'b00} == `OPC_IMM_GRP && ext == `EXT_OR) begin
            dec.op     = OP_OR;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_RM_TO_MEM;
        end else if ({opcode_i[7:2], 2'b00} == `OPC_IMM_GRP && ext == `EXT_XOR) begin
            dec.op     = OP_XOR;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_RM_TO_MEM;
        end else if (opc_w0 == `OPC_TEST_RM) begin
            dec.op     = OP_TEST;
            dec.writes = 1'b0;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_TEST_MEM;
        end else if (opc_w0 == `OPC_UNARY_GRP && ext == `EXT_TEST) begin
            dec.op     = OP_TEST;
            dec.writes = 1'b0;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_TEST_MEM;
        end else if (opc_w0 == `OPC_UNARY_GRP && ext == `EXT_NOT) begin
            dec.op     = OP_NOT;
            dec.clocks = reg_form ? `CLK_REG_OP : `CLK_NOT_MEM;
        end else if (opc_w0 == `OPC_TEST_ACC) begin
            dec.op     = OP_TEST;
            dec.writes = 1'b0;
        end else if (opc_dw0 == `OPC_OR_RM && (opcode_i[1] ? reg_form : 1'b1) && reg_form) begin
            dec.op     = OP_OR;
        end else if (opc_w0 == `OPC_OR_RM) begin
            dec.op     = OP_OR;
            dec.clocks = `CLK_RM_TO_MEM;
        end else if (opc_w0 == `OPC_OR_MR) begin
            dec.op     = OP_OR;
            dec.clocks = `CLK_MEM_TO_REG;
        end else if (opc_w0 == `OPC_OR_ACC) begin
            dec.op     = OP_OR;
        end else if (opc_dw0 == `OPC_XOR_RM && reg_form) begin
            dec.op     = OP_XOR;
        end else if (opc_w0 == `OPC_XOR_RM) begin
            dec.op     = OP_XOR;
            dec.clocks = `CLK_RM_TO_MEM;
        end else if (opc_w0 == `OPC_XOR_MR) begin
            dec.op     = OP_XOR;
            dec.clocks = `CLK_MEM_TO_REG;
        end else if (opc_w0 == `OPC_XOR_ACC) begin
            dec.op     = OP_XOR;
        end else if (opc_w0 == `OPC_STR_CMP) begin
            dec.op     = OP_SCMP;
            dec.writes = 1'b0;
            dec.clocks = dec.repeat_eq ? `CLK_REPT_BASE : `CLK_CMP;
        end else if (opc_w0 == `OPC_STR_IN) begin
            dec.op     = OP_SIN;
            if (mode_i == MODE_REAL)
                dec.clocks = `CLK_IN_REAL;
            else if (mode_i == MODE_PROTECTED && io_low)
                dec.clocks = `CLK_IN_LOW;
            else
                dec.clocks = `CLK_IN_HIGH;
        end else if (opc_w0 == `OPC_STR_OUT) begin
            dec.op     = OP_SOUT;
            if (mode_i == MODE_REAL)
                dec.clocks = `CLK_OUT_REAL;
            else if (mode_i == MODE_PROTECTED && io_low)
                dec.clocks = `CLK_OUT_LOW;
            else
                dec.clocks = `CLK_OUT_HIGH;
        end else if (opc_w0 == `OPC_STR_LOAD) begin
            dec.op     = OP_SLOAD;
            dec.clocks = `CLK_LOAD;
        end else if (opc_w0 == `OPC_STR_MOVE) begin
            dec.op     = OP_SMOVE;
            dec.clocks = `CLK_MOVE;
        end else if (opc_w0 == `OPC_STR_SCAN) begin
            dec.op     = OP_SSCAN;
            dec.writes = 1'b0;
            dec.clocks = `CLK_SCAN;
        end else if (opc_w0 == `OPC_STR_STORE) begin
            dec.op     = OP_SSTOR;
            dec.clocks = `CLK_STORE;
        end else begin
            dec.valid  = 1'b0;                                 // Unknown opcode
            dec.writes = 1'b0;
            dec.clocks = 8'h01;
        end
    end
endmodule : op_decoder

// ==== core/logic_string_seq.sv ====
// Top: takes an instruction, decodes it and times its execution
//
// Overview of operation
// - And reg-to-mem 7 clocks, mem-to-reg 6
// - Immediate group field 100 is and, 2/7
// - Accumulator and immediate short form, 2 clocks
// - Test reg/mem with reg, flags only, 2/5
// - Immediate test field 000 2/5, accumulator 2
// - Or forms: 2, 7, 6 clocks
// - Immediate or field 001 2/7, accumulator 2
// - Xor forms: 2, 7, 6 clocks
// - Immediate xor field 110, 2/7 clocks
// - Accumulator xor immediate short form, 2 clocks
// - Invert field 010, 2/6 clocks
// - String compare takes 10 clocks without the equal-repeat prefix
// - Port input string 15, 29, 9/29
// - Port output string 14, 28, 8/28
// - In protected mode only, privileged enough picks shorter port count
// - String load takes 5 clocks
// - String move takes 8 clocks
// - String scan takes 8 clocks
// - String store takes 5 clocks
// - Table translate opcode D7, 5 clocks
// - Equal-repeat compare costs 5 plus 9n
`timescale 1ns/1ps
`include "logic_string_cfg.svh"
module logic_string_seq
    import logic_string_pkg::*;
(
    input  wire logic        clk_i,           // Core clock
    input  wire logic        rstn_i,          // Synchronous reset, active low
    input  wire logic        start_i,         // Instruction presented
    input  wire logic        prefix_valid_i,  // Prefix byte present
    input  wire logic [7:0]  prefix_i,        // Prefix byte
    input  wire logic [7:0]  opcode_i,        // Opcode byte
    input  wire logic [7:0]  modrm_i,         // Addressing byte
    input  wire logic [1:0]  mode_i,          // Operating mode
    input  wire logic [1:0]  current_privilege_level_i, // Current privilege level
    input  wire logic [1:0]  io_privilege_threshold_i,  // I/O privilege threshold
    input  wire logic        addr32_i,        // Use 32-bit count register
    input  wire logic [31:0] count_i,         // Count register value
    input  wire logic        equal_i,         // Compared elements equal
    output logic             ready_o,         // Can accept an instruction
    output logic             done_o,          // Instruction finished, pulse
    output logic             illegal_o,       // Last opcode unknown
    output logic [3:0]       op_o,            // Decoded operation
    output logic             full_width_o,    // Full-width operand
    output logic             writes_o,        // Result is written back
    output logic [15:0]      cycles_o,        // Clocks spent on last instruction
    output logic [31:0]      count_o          // Count register after repeat
);
    decode_bus_if dbus ();                    // Decoder to sequencer

    seq_state_t  state_reg;                   // Sequencer state
    logic [7:0]  tick_reg;                    // Clocks left in current phase
    logic [31:0] cnt_reg;                     // Remaining iterations
    logic        rep_reg;                     // Repeating compare
    logic [15:0] cyc_reg;                     // Clocks spent so far
    logic [7:0]  iter_reg;                    // Clocks per iteration
    logic        last_tick;                   // Phase ends this clock
    logic [31:0] masked_cnt;                  // Count sized to address width

    // Decoder instance
    op_decoder u_dec (
        .prefix_valid_i (prefix_valid_i),
        .prefix_i       (prefix_i),
        .opcode_i       (opcode_i),
        .modrm_i        (modrm_i),
        .mode_i         (cpu_mode_t'(mode_i)),
        .current_privilege_level_i (current_privilege_level_i),
        .io_privilege_threshold_i  (io_privilege_threshold_i),
        .dec            (dbus.producer)
    );

    assign last_tick  = (tick_reg == 8'h01);
    assign masked_cnt = addr32_i ? count_i : {16'h0000, count_i[15:0]};
    assign ready_o    = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
    assign done_o     = (state_reg == ST_DONE);

    // State sequencing
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE, ST_DONE: begin
                    if (start_i)
                        state_reg <= ST_EXEC;
                    else
                        state_reg <= ST_IDLE;
                end
                ST_EXEC: begin
                    if (last_tick)
                        state_reg <= (rep_reg && cnt_reg != 32'h0) ? ST_REPEAT : ST_DONE;
                end
                ST_REPEAT: begin
                    // Stop when this iteration empties the count or mismatches
                    if (last_tick && (cnt_reg == 32'h1 || !equal_i))
                        state_reg <= ST_DONE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Phase clock counter
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tick_reg <= 8'h00;
            iter_reg <= 8'h00;
        end else if (ready_o && start_i) begin
            tick_reg <= dbus.clocks;
            iter_reg <= dbus.iter_clocks;
        end else if ((state_reg == ST_EXEC || state_reg == ST_REPEAT) && last_tick) begin
            tick_reg <= iter_reg;
        end else if (tick_reg != 8'h00) begin
            tick_reg <= tick_reg - 8'h01;
        end
    end

    // Repeat count, one per iteration
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= 32'h0;
            rep_reg <= 1'b0;
        end else if (ready_o && start_i) begin
            cnt_reg <= masked_cnt;
            rep_reg <= dbus.repeat_eq;
        end else if (state_reg == ST_REPEAT && last_tick && cnt_reg != 32'h0) begin
            cnt_reg <= cnt_reg - 32'h1;
        end
    end

    // Spent-clock tally
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            cyc_reg <= 16'h0000;
        else if (ready_o && start_i)
            cyc_reg <= 16'h0001;
        else if (state_reg == ST_EXEC || state_reg == ST_REPEAT)
            cyc_reg <= cyc_reg + 16'h0001;
    end

    // Result outputs captured at acceptance and completion
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            op_o         <= 4'h0;
            full_width_o <= 1'b0;
            writes_o     <= 1'b0;
            illegal_o    <= 1'b0;
            cycles_o     <= 16'h0000;
            count_o      <= 32'h0;
        end else begin
            if (ready_o && start_i) begin
                op_o         <= dbus.op;
                full_width_o <= dbus.full_width;
                writes_o     <= dbus.writes;
                illegal_o    <= !dbus.valid;
            end
            if ((state_reg == ST_EXEC || state_reg == ST_REPEAT) && last_tick) begin
                cycles_o <= cyc_reg;
                count_o  <= (state_reg == ST_REPEAT) ? cnt_reg - 32'h1 : cnt_reg;
            end
        end
    end
endmodule : logic_string_seq

// ==== test/logic_string_seq_assertions.sv ====
// Checker for decode and timing at the ports of the sequencer
`timescale 1ns/1ps
module logic_string_seq_assertions
    import logic_string_pkg::*;
(
    input wire logic       clk_i,          // Clock
    input wire logic       rstn_i,         // Reset, active low
    input wire logic       start_i,        // Request
    input wire logic       prefix_valid_i, // Prefix present
    input wire logic [7:0] opcode_i,       // Opcode
    input wire logic [7:0] modrm_i,        // Addressing byte
    input wire logic [1:0] mode_i,         // Mode
    input wire logic [1:0] current_privilege_level_i, // Privilege level
    input wire logic [1:0] io_privilege_threshold_i,  // I/O threshold
    input wire logic       ready_o,        // Ready
    input wire logic       done_o,         // Done pulse
    input wire logic       illegal_o,      // Unknown opcode
    input wire logic [3:0] op_o,           // Operation
    input wire logic       full_width_o,   // Width
    input wire logic       writes_o        // Write back
);
    // Plain instruction taken at this edge
    wire logic       acc = ready_o && start_i && !prefix_valid_i;
    wire logic [6:0] opc = opcode_i[7:1];  // Opcode without width bit
    wire logic       io_ok = (current_privilege_level_i <= io_privilege_threshold_i); // Short

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_and_mem_lat: assert property (acc && opc == 7'h10 && modrm_i[7:6] != 2'h3
        |=> (!done_o)[*7] ##1 done_o) else $error("and to memory not 7 clocks");
    a_and_acc_lat: assert property (acc && opc == 7'h12
        |=> (!done_o)[*2] ##1 done_o) else $error("short and not 2 clocks");
    a_test_no_write: assert property (acc && opc == 7'h42
        |=> !writes_o && op_o == OP_TEST) else $error("test writes a result");
    a_cmp_lat: assert property (acc && opc == 7'h53
        |=> (!done_o)[*8] ##3 done_o) else $error("compare not 10 clocks");
    a_in_short: assert property (acc && opc == 7'h36 && mode_i == 2'h2 && io_ok
        |-> ##10 done_o) else $error("privileged port input not 9 clocks");
    a_out_long: assert property (acc && opc == 7'h37 && mode_i == 2'h2 && !io_ok
        |-> ##29 done_o) else $error("unprivileged port output not 28 clocks");
    a_table_lookup_translate_lat: assert property (acc && opcode_i == 8'hD7
        |-> ##6 done_o) else $error("translate not 5 clocks");
    a_width_bit: assert property (acc && opcode_i != 8'hD7
        |=> illegal_o || full_width_o == $past(opcode_i[0])) else $error("width bit lost");
    a_done_pulse: assert property (done_o && !start_i |=> !done_o)
        else $error("done longer than one cycle");
    a_busy_refuse: assert property (!ready_o && start_i |=> $stable(op_o))
        else $error("start taken while busy");

    // Main scenarios
    c_repeat: cover property (ready_o && start_i && prefix_valid_i);
    c_back2back: cover property (done_o && start_i);
    c_refused: cover property (!ready_o && start_i);
endmodule : logic_string_seq_assertions

bind logic_string_seq logic_string_seq_assertions chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .prefix_valid_i(prefix_valid_i),
    .opcode_i(opcode_i), .modrm_i(modrm_i), .mode_i(mode_i),
    .current_privilege_level_i(current_privilege_level_i),
    .io_privilege_threshold_i(io_privilege_threshold_i),
    .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
    .op_o(op_o), .full_width_o(full_width_o), .writes_o(writes_o));

// ==== test/logic_string_seq_tb.sv ====
// Self-checking bench for the logic and string sequencer
`timescale 1ns/1ps
module logic_string_seq_tb;
    import logic_string_pkg::*;
    // Expected outcome of one instruction
    typedef struct packed {
        logic [3:0]  op;   // Operation
        logic        fw;   // Full width
        logic        wr;   // Writes back
        logic [2:0]  chk;  // Check count, write, width
        logic        ill;  // Unknown opcode
        logic [15:0] cnt;  // Count after repeat
        logic [15:0] lat;  // Clocks to done
        logic [15:0] acc;  // Accept cycle
    } note_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, prefix_valid_i = 1'b0;
    logic addr32_i = 1'b0, equal_i = 1'b0, pv = 1'b0;
    logic [7:0]  prefix_i = 8'h0, opcode_i = 8'h0, modrm_i = 8'h0;
    logic [1:0]  mode_i = 2'h0, current_privilege_level_i = 2'h0;
    logic [1:0]  io_privilege_threshold_i = 2'h0;
    logic [31:0] count_i = 32'h0;
    logic        ready_o, done_o, illegal_o, full_width_o, writes_o;
    logic [3:0]  op_o;
    logic [15:0] cycles_o, cnt_exp = 16'h0, cyc = 16'h0;
    logic [31:0] count_o;
    note_t       exp_q[$];  // Pending expectations
    note_t       got;       // Note being compared
    int          n_mismatch = 0, tests_run = 0, li;

    logic_string_seq dut (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
        .prefix_valid_i(prefix_valid_i), .prefix_i(prefix_i), .opcode_i(opcode_i),
        .modrm_i(modrm_i), .mode_i(mode_i),
        .current_privilege_level_i(current_privilege_level_i),
        .io_privilege_threshold_i(io_privilege_threshold_i),
        .addr32_i(addr32_i), .count_i(count_i), .equal_i(equal_i), .ready_o(ready_o),
        .done_o(done_o), .illegal_o(illegal_o), .op_o(op_o), .full_width_o(full_width_o),
        .writes_o(writes_o), .cycles_o(cycles_o), .count_o(count_o));

    always #5 clk_i = ~clk_i;

    task automatic fail(input string m);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : fail

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Cycle count and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 16'h1;
        if (cyc == 16'h1388) begin
            fail("timeout");
            report_and_stop();
        end
    end

    // Compare each done pulse with the oldest note
    always @(negedge clk_i) begin
        if (rstn_i === 1'b1 && done_o === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected done");
            else begin
                got = exp_q.pop_front();
                tests_run++;
                if (cyc - got.acc !== got.lat) fail("latency");
                if (cycles_o !== got.lat) fail("cycles spent");
                if (illegal_o !== got.ill) fail("illegal flag");
                if (!got.ill && op_o !== got.op) fail("operation");
                if (got.chk[0] && full_width_o !== got.fw) fail("width");
                if (got.chk[1] && writes_o !== got.wr) fail("write back");
                if (got.chk[2] && count_o[15:0] !== got.cnt) fail("count");
            end
        end
    end

    function automatic logic [7:0] rb(input logic [7:0] m);
        return 8'($urandom) & m;
    endfunction : rb

    // Present one instruction and note what it should give
    task automatic issue(input logic [7:0] opc, input logic [7:0] mrm, input logic [3:0] op,
                         input logic wr, input logic [2:0] chk, input logic ill, input int lat);
        while (ready_o !== 1'b1) @(negedge clk_i);
        start_i = 1'b1;
        opcode_i = opc;
        modrm_i = mrm;
        prefix_valid_i = pv;
        prefix_i = pv ? 8'hF3 : rb(8'hFF);
        exp_q.push_back(note_t'{op, opc[0], wr, chk, ill, cnt_exp, 16'(lat), cyc + 16'h1});
        @(negedge clk_i);
        start_i = 1'b0;
    endtask : issue

    task automatic drain();
        while (exp_q.size() != 0) @(negedge clk_i);
    endtask : drain

    // Memory form then register form of one opcode
    task automatic run_rm(input logic [7:0] b, input logic [7:0] m, input logic [2:0] x,
                          input int rl, input int ml, input logic [3:0] op, input logic wr);
        for (int r = 0; r < 2; r++) begin
            issue(b | rb(m), {(r == 1) ? 2'h3 : 2'($urandom_range(2, 0)), x, 3'($urandom)},
                  op, wr, 3'b011, 1'b0, (r == 1) ? rl : ml);
        end
    endtask : run_rm

    // Prefixed compare with a given count
    task automatic rep(input logic a, input logic [31:0] c, input logic eq, input int it);
        drain();
        pv = 1'b1;
        addr32_i = a;
        count_i = c;
        equal_i = eq;
        cnt_exp = c[15:0] - 16'(it);
        issue(8'hA6 | rb(8'h01), rb(8'hFF), OP_SCMP, 1'b0, 3'b101, 1'b0, 5 + 9 * it);
        drain();
        pv = 1'b0;
    endtask : rep

    initial begin
        void'($urandom(32'hDB6A));
        mode_i = 2'($urandom_range(2, 0));
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        run_rm(8'h20, 8'h01, 3'($urandom), 2, 7, OP_AND, 1'b1);
        run_rm(8'h22, 8'h01, 3'($urandom), 2, 6, OP_AND, 1'b1);
        run_rm(8'h80, 8'h03, 3'h4, 2, 7, OP_AND, 1'b1);
        run_rm(8'h84, 8'h01, 3'($urandom), 2, 5, OP_TEST, 1'b0);
        run_rm(8'hF6, 8'h01, 3'h0, 2, 5, OP_TEST, 1'b0);
        run_rm(8'h08, 8'h01, 3'($urandom), 2, 7, OP_OR, 1'b1);
        run_rm(8'h0A, 8'h01, 3'($urandom), 2, 6, OP_OR, 1'b1);
        run_rm(8'h80, 8'h03, 3'h1, 2, 7, OP_OR, 1'b1);
        run_rm(8'h30, 8'h01, 3'($urandom), 2, 7, OP_XOR, 1'b1);
        run_rm(8'h32, 8'h01, 3'($urandom), 2, 6, OP_XOR, 1'b1);
        run_rm(8'h80, 8'h03, 3'h6, 2, 7, OP_XOR, 1'b1);
        run_rm(8'hF6, 8'h01, 3'h2, 2, 6, OP_NOT, 1'b1);
        issue(8'h24 | rb(8'h01), rb(8'hFF), OP_AND, 1'b1, 3'b011, 1'b0, 2);
        issue(8'hA8 | rb(8'h01), rb(8'hFF), OP_TEST, 1'b0, 3'b011, 1'b0, 2);
        issue(8'h0C | rb(8'h01), rb(8'hFF), OP_OR, 1'b1, 3'b011, 1'b0, 2);
        issue(8'h34 | rb(8'h01), rb(8'hFF), OP_XOR, 1'b1, 3'b011, 1'b0, 2);
        issue(8'hA6 | rb(8'h01), rb(8'hFF), OP_SCMP, 1'b0, 3'b001, 1'b0, 10);
        issue(8'hAC | rb(8'h01), rb(8'hFF), OP_SLOAD, 1'b0, 3'b001, 1'b0, 5);
        issue(8'hA4 | rb(8'h01), rb(8'hFF), OP_SMOVE, 1'b0, 3'b001, 1'b0, 8);
        issue(8'hAE | rb(8'h01), rb(8'hFF), OP_SSCAN, 1'b0, 3'b001, 1'b0, 8);
        issue(8'hAA | rb(8'h01), rb(8'hFF), OP_SSTOR, 1'b0, 3'b001, 1'b0, 5);
        issue(8'hD7, rb(8'hFF), OP_TRANS, 1'b0, 3'b000, 1'b0, 5);
        issue(8'hC8, rb(8'hFF), OP_NONE, 1'b0, 3'b000, 1'b1, 1);
        // Port strings: real, virtual, privileged at the boundary, unprivileged
        for (int k = 0; k < 4; k++) begin
            drain();
            mode_i = (k < 2) ? 2'(k) : 2'h2;
            io_privilege_threshold_i = (k == 3) ? 2'h0 : 2'($urandom);
            current_privilege_level_i = (k == 2) ? io_privilege_threshold_i
                                                 : 2'h1 + 2'($urandom_range(2, 0));
            li = (k == 0) ? 15 : (k == 2) ? 9 : 29;
            issue(8'h6C | rb(8'h01), rb(8'hFF), OP_SIN, 1'b0, 3'b001, 1'b0, li);
            issue(8'h6E | rb(8'h01), rb(8'hFF), OP_SOUT, 1'b0, 3'b001, 1'b0, li - 1);
        end
        // Start held while busy must be ignored
        issue(8'h6C, rb(8'hFF), OP_SIN, 1'b0, 3'b001, 1'b0, 29);
        @(negedge clk_i);
        start_i = 1'b1;
        opcode_i = 8'hA4;
        repeat (3) @(negedge clk_i);
        start_i = 1'b0;
        drain();
        rep(1'b0, {16'($urandom), 16'h0}, 1'b1, 0);
        rep(1'b0, {16'($urandom), 16'h3}, 1'b1, 3);
        rep(1'b1, 32'h2, 1'b1, 2);
        rep(1'b0, {16'($urandom), 16'h4}, 1'b0, 1);
        // Reset in mid-run clears everything
        issue(8'h6C, rb(8'hFF), OP_SIN, 1'b0, 3'b001, 1'b0, 29);
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        exp_q.delete();
        tests_run++;
        if (ready_o !== 1'b1 || done_o !== 1'b0 || op_o !== 4'h0 || writes_o !== 1'b0
            || illegal_o !== 1'b0 || cycles_o !== 16'h0 || count_o !== 32'h0)
            fail("reset state");
        rstn_i = 1'b1;
        issue(8'hD7, rb(8'hFF), OP_TRANS, 1'b0, 3'b000, 1'b0, 5);
        drain();
        report_and_stop();
    end
endmodule : logic_string_seq_tb
